/* dv/qadc_host.sv */
// Host serial port model that frames conversions and collects results.
`timescale 1ns/1ns
module qadc_host #(
	parameter HP = 20
) (
	// Serial pins
	input  wire        clk_sys,
	output logic       cs_n,
	output logic       sclk,
	output logic       din,
	input  wire        dout,
	// Collected result
	output logic [11:0] word,
	output logic       word_done
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
		word = 12'h000;
		word_done = 1'b0;
	end

	task automatic wt(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask

	// Mode 0 rests low, mode 1 rests high, mode 2 drops clock with select.
	task automatic frame(input int n, input int mode, input logic [63:0] ctl);
		sclk = (mode != 0);
		wt(HP);
		cs_n = 1'b0;
		if (mode == 2)
			sclk = 1'b0;
		if (mode == 1) begin
			wt(HP);
			sclk = 1'b0;
		end
		din = ctl[7];
		for (int c = 0; c < n; c++) begin
			for (int r = 1; r <= 16; r++) begin
				wt(HP);
				sclk = 1'b1;
				if (r >= 5)
					word = {word[10:0], dout};
				word_done = (r == 16);
				wt(HP);
				word_done = 1'b0;
				if (!(mode == 1 && c == n - 1 && r == 16))
					sclk = 1'b0;
				// A released input toggles rather than holding its last bit.
				din = (r < 8) ? ctl[8*c+7-r] : (r == 16) ? ctl[(8*c+15)%64] : ~din;
			end
		end
		wt(HP);
		cs_n = 1'b1;
	endtask

	task automatic noise(input int k);
		repeat (2 * k) begin
			wt(HP);
			sclk = ~sclk;
		end
	endtask
endmodule

/* dv/qadc_properties.sv */
// Port assertions for the quad converter frame controller.
`timescale 1ns/1ns
module qadc_props (
	// Clock and reset
	input wire        clk_sys,
	input wire        rst_n,
	// Serial pins
	input wire        cs_n,
	input wire        dout,
	input wire        dout_oe_n,
	// Front end and result stream
	input wire [11:0] dac_code,
	input wire [1:0]  chan_sel,
	input wire        track_mode,
	input wire        hold_mode,
	input wire        sample_strobe,
	input wire        power_down,
	input wire [11:0] res_data,
	input wire        res_valid,
	input wire        res_ready,
	input wire        res_overrun
);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_oe_on; $fell(cs_n) |-> ##[1:4] !dout_oe_n; endproperty
	a_oe_on: assert property (p_oe_on) else $error("dout not driven in frame");
	property p_oe_off; cs_n [*5] |-> dout_oe_n; endproperty
	a_oe_off: assert property (p_oe_off) else $error("dout driven while idle");
	property p_pd; cs_n [*5] |-> power_down && !track_mode && !hold_mode; endproperty
	a_pd: assert property (p_pd) else $error("active while deselected");
	property p_awake; (track_mode || hold_mode) |-> !power_down; endproperty
	a_awake: assert property (p_awake) else $error("powered down while busy");
	property p_gap; $fell(hold_mode) |-> power_down && !track_mode; endproperty
	a_gap: assert property (p_gap) else $error("awake after conversion end");
	property p_excl; !(track_mode && hold_mode); endproperty
	a_excl: assert property (p_excl) else $error("track and hold together");
	property p_hold; $rose(hold_mode) |-> $past(track_mode) && dac_code == 12'h800; endproperty
	a_hold: assert property (p_hold) else $error("hold start wrong");
	property p_strobe; $rose(hold_mode) |-> sample_strobe ##1 !sample_strobe; endproperty
	a_strobe: assert property (p_strobe) else $error("sample strobe wrong");
	property p_lead; track_mode && $past(track_mode) |-> !dout; endproperty
	a_lead: assert property (p_lead) else $error("dout not zero in track");
	property p_chan; hold_mode |-> $stable(chan_sel); endproperty
	a_chan: assert property (p_chan) else $error("channel moved in hold");
	property p_res; res_valid && !res_ready |=> res_valid && $stable(res_data); endproperty
	a_res: assert property (p_res) else $error("result dropped while stalled");
	property p_ovr; res_overrun |-> res_valid; endproperty
	a_ovr: assert property (p_ovr) else $error("overrun with room left");
endmodule

/* dv/quad_adc_serial_frame_control_bench.sv */
// Self-checking bench for the quad converter frame controller.
`timescale 1ns/1ns
module quad_adc_serial_frame_control_bench;
	logic        clk_sys, rst_n, res_ready, stall;
	wire         cs_n, sclk, din, dout, dout_oe_n, cmp_above, track_mode, hold_mode;
	wire         sample_strobe, power_down, res_valid, res_overrun, word_done;
	wire  [11:0] dac_code, res_data, word;
	wire  [1:0]  chan_sel;
	logic [11:0] ana [4];
	logic [11:0] exp_ser[$], exp_par[$];
	logic [1:0]  cur_ch = 2'h0;
	int          error_cnt = 0, n_tests = 0, cyc = 0, n_ovr = 0;

	assign cmp_above = (ana[chan_sel] >= dac_code);

	qadc_frame_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
		.din(din), .dout(dout), .dout_oe_n(dout_oe_n), .cmp_above(cmp_above),
		.dac_code(dac_code), .chan_sel(chan_sel), .track_mode(track_mode),
		.hold_mode(hold_mode), .sample_strobe(sample_strobe), .power_down(power_down),
		.res_data(res_data), .res_valid(res_valid), .res_ready(res_ready),
		.res_overrun(res_overrun));
	qadc_host host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
		.word(word), .word_done(word_done));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk_word(input string k, input logic [11:0] got, inout logic [11:0] q[$]);
		logic [11:0] e;
		e = (q.size() != 0) ? q.pop_front() : 12'hXXX;
		n_tests++;
		if (got !== e) begin
			error_cnt++;
			$display("[FAIL] %0t %s word %h expected %h", $time, k, got, e);
		end
	endtask

	task automatic chk_cnt(input string k, input int got, input int e);
		n_tests++;
		if (got != e) begin
			error_cnt++;
			$display("[FAIL] %0t %s count %0d expected %0d", $time, k, got, e);
		end
	endtask

	// Stream checks, overrun bookkeeping, ready stimulus and the hang limit.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			tally_and_finish();
		end
		if (res_valid === 1'b1 && res_ready === 1'b1)
			chk_word("stream", res_data, exp_par);
		if (res_overrun === 1'b1) begin
			n_ovr++;
			exp_par.delete(2);
		end
		res_ready <= #1 !stall && ($urandom % 2 == 0);
	end

	// The word settles in the same step as its flag, so look one step later.
	always @(posedge word_done) begin
		#1;
		chk_word("serial", word, exp_ser);
	end

	task automatic run(input int n, input int mode, input logic [63:0] ctl, input string nm);
		for (int c = 0; c < n; c++) begin
			exp_ser.push_back(ana[cur_ch]);
			exp_par.push_back(ana[cur_ch]);
			cur_ch = ctl[8*c+3 +: 2];
		end
		host.frame(n, mode, ctl);
		stall = 1'b0;
		for (int t = 0; t < 3000 && exp_par.size() != 0; t++)
			@(posedge clk_sys);
		chk_cnt("left", exp_par.size() + exp_ser.size(), 0);
		$display("test %s done", nm);
	endtask

	task automatic shuffle;
		foreach (ana[i])
			ana[i] = $urandom;
	endtask

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'hE94B));
		rst_n = 1'b0;
		res_ready = 1'b0;
		stall = 1'b0;
		ana = '{12'h000, 12'hFFF, 12'h001, 12'h800};
		repeat (2) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (8) @(posedge clk_sys);
		run(4, 0, 64'h20FF_D008, "first");
		shuffle();
		run(2, 1, {$urandom, $urandom}, "rest_high");
		shuffle();
		run(3, 2, {$urandom, $urandom}, "together");
		host.noise(5);
		run(1, 0, {$urandom, $urandom}, "gated");
		shuffle();
		run(8, 0, 64'h3830_2820_1810_0800, "codes");
		shuffle();
		stall = 1'b1;
		run(4, 0, {$urandom, $urandom}, "overrun");
		chk_cnt("overrun", n_ovr, 1);
		repeat (3) begin
			shuffle();
			run(1 + $urandom % 3, $urandom % 3, {$urandom, $urandom}, "random");
		end
		tally_and_finish();
	end
endmodule

bind qadc_frame_ctrl qadc_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n),
	.dout(dout), .dout_oe_n(dout_oe_n), .dac_code(dac_code), .chan_sel(chan_sel),
	.track_mode(track_mode), .hold_mode(hold_mode), .sample_strobe(sample_strobe),
	.power_down(power_down), .res_data(res_data), .res_valid(res_valid),
	.res_ready(res_ready), .res_overrun(res_overrun));

/* hdl/qadc_frame_ctrl.v */
// Serial frame, conversion sequencing and result path of the quad converter.
`timescale 1ns/1ns
`include "qadc_regs.vh"

module qadc_frame_ctrl (
	// Clock and reset
	input  wire                    clk_sys,
	input  wire                    rst_n,
	// Serial pins from the host
	input  wire                    cs_n,
	input  wire                    sclk,
	input  wire                    din,
	output wire                    dout,
	output wire                    dout_oe_n,
	// Analog front end
	input  wire                    cmp_above,
	output wire [`QADC_RES_W-1:0]  dac_code,
	output wire [`QADC_CHAN_W-1:0] chan_sel,
	output wire                    track_mode,
	output wire                    hold_mode,
	output wire                    sample_strobe,
	output wire                    power_down,
	// Parallel result stream
	output wire [`QADC_RES_W-1:0]  res_data,
	output wire                    res_valid,
	input  wire                    res_ready,
	output wire                    res_overrun
);

	localparam [1:0] ST_PD    = 2'b00;
	localparam [1:0] ST_TRACK = 2'b01;
	localparam [1:0] ST_HOLD  = 2'b10;

	// ------------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------------
	reg rst_m_q;
	reg rst_s_q;
	wire rst_sync_n;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_s_q <= rst_m_q;
		end
	end

	assign rst_sync_n = rst_s_q;

	// ------------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------------
	reg cs_m_q;
	reg cs_s_q;
	reg cs_d_q;
	reg sclk_m_q;
	reg sclk_s_q;
	reg sclk_d_q;
	reg din_m_q;
	reg din_s_q;

	always @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cs_m_q   <= 1'b1;
			cs_s_q   <= 1'b1;
			cs_d_q   <= 1'b1;
			sclk_m_q <= 1'b0;
			sclk_s_q <= 1'b0;
			sclk_d_q <= 1'b0;
			din_m_q  <= 1'b0;
			din_s_q  <= 1'b0;
		end else begin
			cs_m_q   <= cs_n;
			cs_s_q   <= cs_m_q;
			cs_d_q   <= cs_s_q;
			sclk_m_q <= sclk;
			sclk_s_q <= sclk_m_q;
			sclk_d_q <= sclk_s_q;
			din_m_q  <= din;
			din_s_q  <= din_m_q;
		end
	end

	wire frame_open;
	wire in_frame;
	wire sclk_fall;
	wire sclk_rise;
	wire first_fall;

	assign frame_open = !cs_s_q && cs_d_q;
	// Clock edges count only inside a frame; outside it they are gated off.
	assign in_frame   = !cs_s_q && !cs_d_q;
	assign sclk_fall  = in_frame && sclk_d_q && !sclk_s_q;
	assign sclk_rise  = in_frame && !sclk_d_q && sclk_s_q;
	// A clock resting low, or falling with the select, makes the select fall
	// the first falling edge; the next rising edge then carries control bit 7.
	assign first_fall = frame_open && !sclk_s_q;

	// ------------------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------------------
	reg [1:0]                state_q;
	reg [1:0]                state_d;
	reg [4:0]                fall_q;
	reg [4:0]                fall_d;
	reg [4:0]                rise_q;
	reg [4:0]                rise_d;
	reg [`QADC_CTRL_W-2:0]   shift_q;
	reg [`QADC_CTRL_W-2:0]   shift_d;
	reg [`QADC_CHAN_W-1:0]   chan_addr_q;
	reg [`QADC_CHAN_W-1:0]   chan_addr_d;
	reg [`QADC_CHAN_W-1:0]   mux_q;
	reg [`QADC_CHAN_W-1:0]   mux_d;
	reg                      hold_evt;
	wire                     start_conv;
	wire [`QADC_CTRL_W-1:0]  ctrl_word;

	// A new conversion opens at the first fall of a frame, or at the fall
	// that follows the sixteenth edge of the previous one.
	assign start_conv = first_fall ||
		(sclk_fall && (fall_q == 5'd0 || fall_q == `QADC_CONV_EDGES));
	assign ctrl_word  = {shift_q, din_s_q};

	always @* begin
		state_d     = state_q;
		fall_d      = fall_q;
		rise_d      = rise_q;
		shift_d     = shift_q;
		chan_addr_d = chan_addr_q;
		mux_d       = mux_q;
		hold_evt    = 1'b0;
		if (cs_s_q) begin
			state_d = ST_PD;
			fall_d  = 5'd0;
			rise_d  = 5'd0;
		end else begin
			if (start_conv) begin
				state_d = ST_TRACK;
				fall_d  = 5'd1;
				rise_d  = 5'd0;
				// The input in use was chosen by the previous control word.
				mux_d   = chan_addr_q;
			end else if (sclk_fall) begin
				fall_d = fall_q + 5'd1;
				case (state_q)
				ST_TRACK: begin
					if (fall_d == `QADC_HOLD_FALL) begin
						state_d  = ST_HOLD;
						hold_evt = 1'b1;
					end
				end
				ST_HOLD: begin
					if (fall_d == `QADC_CONV_EDGES) begin
						state_d = ST_PD;
					end
				end
				default: begin
				end
				endcase
			end
			if (sclk_rise && rise_q != `QADC_CONV_EDGES) begin
				rise_d = rise_q + 5'd1;
				if (rise_q < `QADC_CTRL_BITS) begin
					shift_d = ctrl_word[`QADC_CTRL_W-2:0];
				end
				if (rise_d == `QADC_CTRL_BITS) begin
					// Bits 7, 6, 5 and 2 to 0 are dropped here.
					chan_addr_d = ctrl_word[`QADC_CHAN_LSB+`QADC_CHAN_W-1:
						`QADC_CHAN_LSB];
				end
			end
		end
	end

	reg track_q;
	reg hold_q;
	reg pd_q;
	reg sample_q;

	always @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_q     <= ST_PD;
			fall_q      <= 5'd0;
			rise_q      <= 5'd0;
			shift_q     <= {(`QADC_CTRL_W-1){1'b0}};
			chan_addr_q <= `QADC_CHAN_RST;
			mux_q       <= `QADC_CHAN_RST;
			track_q     <= 1'b0;
			hold_q      <= 1'b0;
			pd_q        <= 1'b1;
			sample_q    <= 1'b0;
		end else begin
			state_q     <= state_d;
			fall_q      <= fall_d;
			rise_q      <= rise_d;
			shift_q     <= shift_d;
			chan_addr_q <= chan_addr_d;
			mux_q       <= mux_d;
			track_q     <= (state_d == ST_TRACK);
			hold_q      <= (state_d == ST_HOLD);
			pd_q        <= (state_d == ST_PD);
			sample_q    <= hold_evt;
		end
	end

	// ------------------------------------------------------------------------
	// Successive approximation
	// ------------------------------------------------------------------------
	reg                    busy_q;
	reg [`QADC_RES_W-1:0]  trial_q;
	reg [`QADC_RES_W-1:0]  res_q;
	reg [`QADC_RES_W-1:0]  dac_q;
	reg                    pend_q;
	reg [`QADC_RES_W-1:0]  pend_data_q;
	reg                    overrun_q;
	wire [`QADC_RES_W-1:0] res_next;
	wire                   buf_in_ready;
	wire                   done;

	// One bit is decided per system clock, so all twelve settle well before
	// the host samples the fifth rising edge, even at the top clock rate.
	assign res_next = cmp_above ? (res_q | trial_q) : res_q;
	assign done     = busy_q && trial_q[0];

	always @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			busy_q  <= 1'b0;
			trial_q <= `QADC_RES_ZERO;
			res_q   <= `QADC_RES_ZERO;
			dac_q   <= `QADC_RES_ZERO;
		end else if (hold_evt) begin
			busy_q  <= 1'b1;
			trial_q <= `QADC_RES_TOP;
			res_q   <= `QADC_RES_ZERO;
			dac_q   <= `QADC_RES_TOP;
		end else if (busy_q) begin
			// Unsigned straight-binary code, built from the top bit down.
			res_q   <= res_next;
			trial_q <= trial_q >> 1;
			dac_q   <= res_next | (trial_q >> 1);
			if (trial_q[0]) begin
				busy_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Result hand-off into the buffer
	// ------------------------------------------------------------------------
	// A finished word waits here while the buffer is full; a later word that
	// finds it still waiting replaces it and flags the loss.
	always @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pend_q      <= 1'b0;
			pend_data_q <= `QADC_RES_ZERO;
			overrun_q   <= 1'b0;
		end else begin
			overrun_q <= done && pend_q && !buf_in_ready;
			if (done) begin
				pend_q      <= 1'b1;
				pend_data_q <= res_next;
			end else if (buf_in_ready) begin
				pend_q <= 1'b0;
			end
		end
	end

	qadc_pair_buf #(
		.W (`QADC_RES_W)
	) u_buf (
		.clk_sys   (clk_sys),
		.rst_n     (rst_sync_n),
		.in_valid  (pend_q),
		.in_ready  (buf_in_ready),
		.in_data   (pend_data_q),
		.out_valid (res_valid),
		.out_ready (res_ready),
		.out_data  (res_data)
	);

	// ------------------------------------------------------------------------
	// Serial output
	// ------------------------------------------------------------------------
	reg        dout_q;
	reg        dout_oe_n_q;
	wire [3:0] bit_idx;
	wire       in_data_slot;

	assign bit_idx      = `QADC_BIT_BASE - fall_q[3:0];
	assign in_data_slot = (fall_q >= `QADC_DATA_FIRST) && (fall_q <= `QADC_DATA_LAST);

	always @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			dout_q      <= 1'b0;
			dout_oe_n_q <= 1'b1;
		end else begin
			// The select alone decides whether the pin is driven.
			dout_oe_n_q <= cs_s_q;
			if (!cs_s_q && in_data_slot) begin
				dout_q <= res_q[bit_idx];
			end else begin
				dout_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign dout          = dout_q;
	assign dout_oe_n     = dout_oe_n_q;
	assign dac_code      = dac_q;
	assign chan_sel      = mux_q;
	assign track_mode    = track_q;
	assign hold_mode     = hold_q;
	assign sample_strobe = sample_q;
	assign power_down    = pd_q;
	assign res_overrun   = overrun_q;

endmodule

/* hdl/qadc_pair_buf.v */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ns
`include "qadc_regs.vh"

module qadc_pair_buf #(
	parameter W = `QADC_RES_W
) (
	// Clock and reset
	input  wire         clk_sys,
	input  wire         rst_n,
	// Filling side
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// Draining side
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);

	reg [W-1:0] mem_q [0:1];
	reg [1:0]   cnt_q;
	reg         valid_q;
	wire        push;
	wire        pop;

	assign in_ready  = (cnt_q != 2'd2);
	assign out_valid = valid_q;
	assign out_data  = mem_q[0];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Entry 0 is always the head, so the drain side reads a flop directly.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q    <= 2'd0;
			valid_q  <= 1'b0;
			mem_q[0] <= {W{1'b0}};
			mem_q[1] <= {W{1'b0}};
		end else begin
			case ({push, pop})
			2'b10: begin
				mem_q[cnt_q[0]] <= in_data;
				cnt_q           <= cnt_q + 2'd1;
				valid_q         <= 1'b1;
			end
			2'b01: begin
				mem_q[0] <= mem_q[1];
				cnt_q    <= cnt_q - 2'd1;
				valid_q  <= (cnt_q == 2'd2);
			end
			2'b11: begin
				if (cnt_q == 2'd1) begin
					mem_q[0] <= in_data;
				end else begin
					mem_q[0] <= mem_q[1];
					mem_q[1] <= in_data;
				end
			end
			default: begin
			end
			endcase
		end
	end

endmodule

/* hdl/qadc_regs.vh */
// Constants of the quad converter serial frame and conversion sequencer.
`ifndef QADC_REGS_VH
`define QADC_REGS_VH

// ----------------------------------------------------------------------------
// Conversion timing in serial clock edges
// ----------------------------------------------------------------------------
`define QADC_CONV_EDGES   5'd16
`define QADC_HOLD_FALL    5'd4
`define QADC_DATA_FIRST   5'd5
`define QADC_DATA_LAST    5'd16
`define QADC_CTRL_BITS    5'd8

// ----------------------------------------------------------------------------
// Channel select control word
// ----------------------------------------------------------------------------
`define QADC_CTRL_W       8
`define QADC_CHAN_LSB     3
`define QADC_CHAN_W       2
`define QADC_CHAN_RST     2'h0

// ----------------------------------------------------------------------------
// Result
// ----------------------------------------------------------------------------
`define QADC_RES_W        12
`define QADC_RES_TOP      12'h800
`define QADC_RES_ZERO     12'h000
// The bit index wraps modulo sixteen, so fall five picks bit 11 and fall sixteen bit 0.
`define QADC_BIT_BASE     4'h0

`endif
